// >>> charger_pin_control.sv
// Pin-level control and status logic of a single-cell charger.
// Assumes pin inputs synchronous to clk; analog levels arrive as flags.
// Rules for this block and for the host that drives its pins
// RULE_01: Source-select high means USB host source, low means adapter.
// RULE_02: Power-good pulls low only with supply in window and limit over 30mA.
// RULE_03: Charge-status pin held low while a charge cycle runs.
// RULE_04: Charge-status released high when charge done or disabled.
// RULE_05: Any fault adds a weak resistive pull on charge-status.
// RULE_06: Status change or fault gives one 256us low interrupt pulse.
// RULE_07: USB host in buck mode: limit pin high 500mA, low 100mA.
// RULE_08: Boost only when mode field is 10 and limit/boost pin high.
// RULE_09: Charging only when mode field is 01 and charge-enable pin low.
// RULE_10: Outside party always drives charge-enable pin to a defined level.
// RULE_11: Effective limit is the smaller of resistor and register limits.
// RULE_12: Resistor-set limit never counts below 500mA.
// RULE_13: Charging suspended while either thermistor is out of window.
// RULE_14: Interrupt raised at once on a fault, without waiting for a poll.
// RULE_15: Other mode field values enable neither charging nor boost.
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps

module charger_pin_control #(
    parameter int PULSE_CYCLES = charger_pkg::INT_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    // Wishbone classic slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [7:0]                    adr_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // Control pins
    input  wire logic                          sourceSelect,
    input  wire logic                          boostOrLimitSel,
    input  wire logic                          chargeEnable_b,
    // Analog qualifiers
    input  wire charger_pkg::supply_sense_type supplySense,
    input  wire logic [2:0]                    inputLimitResistorPin,
    input  wire logic                          thermistorSenseA,
    input  wire logic                          thermistorSenseB,
    input  wire logic                          chargeDone,
    input  wire logic                          faultDetect,
    // Power stage controls
    output logic                               chargeActive,
    output logic                               boostActive,
    output logic      [2:0]                    effectiveLimit,
    // Open-drain pins
    output logic                               powerGoodNOut,
    output logic                               powerGoodNOe_b,
    output logic                               statOut,
    output logic                               statOe_b,
    output logic                               statFaultPull,
    output logic                               intOut,
    output logic                               intOe_b,
    // Level interrupt
    output logic                               irq
);
    import charger_pkg::*;

    // Pulse counter is 16 bits and needs at least two low cycles
    if (PULSE_CYCLES < 2 || PULSE_CYCLES > 65535) begin : g_pulseRange
        $error("PULSE_CYCLES out of range");
    end

    logic [31:0]       ctrl_r;
    logic [EV_W-1:0]   intStatus_r;
    logic [EV_W-1:0]   intMask_r;
    logic [EV_W-1:0]   intStatusNxt;
    logic [EV_W-1:0]   events;
    logic [15:0]       pulseCnt_r;
    pulse_state_type   pulseState_r;
    logic              faultActive_r;
    logic              thermOk_r;
    logic              done_r;
    logic [1:0]        modeField;
    logic [2:0]        limitCode;
    logic [2:0]        resLimit;
    logic [2:0]        limitNxt;
    logic              chargeReq;
    logic              boostNxt;
    logic              thermOk;
    logic              powerGoodNxt;
    logic              chargeNxt;
    logic              faultNow;
    logic              wbReq;
    logic              wbWrite;

    // Control fields from the software-owned register
    assign modeField = ctrl_r[MODE_LSB+1:MODE_LSB];
    assign limitCode = ctrl_r[LIMIT_LSB+2:LIMIT_LSB];

    // Mode decode; reserved codes fall through to neither function
    assign chargeReq = (modeField == MODE_CHARGE) && !chargeEnable_b; // see RULE_09, RULE_15
    assign boostNxt  = (modeField == MODE_BOOST) && boostOrLimitSel;  // see RULE_08, RULE_15
    assign thermOk   = thermistorSenseA && thermistorSenseB;          // see RULE_13
    assign faultNow  = faultDetect || !thermOk;

    // Limit selection; a small resistor is treated as the 500mA floor
    always_comb begin
        resLimit = (inputLimitResistorPin < LIM_500) ? LIM_500
                                                     : inputLimitResistorPin; // see RULE_12
        limitNxt = (resLimit < limitCode) ? resLimit : limitCode;           // see RULE_11
        // USB host source caps further by the limit pin
        if (sourceSelect && !boostNxt) begin // see RULE_01
            if (!boostOrLimitSel) begin
                limitNxt = LIM_100; // see RULE_07
            end else if (limitNxt > LIM_500) begin
                limitNxt = LIM_500; // see RULE_07
            end
        end
    end

    // Input judged good only inside every supply window
    assign powerGoodNxt = supplySense.aboveLockout && supplySense.belowOvp
                       && supplySense.aboveSleep
                       && (LIMIT_MA[limitNxt] > GOOD_MIN_MA); // see RULE_02

    // A cycle runs only while requested, cool enough and not finished
    assign chargeNxt = chargeReq && thermOk && !chargeDone
                    && !faultDetect && powerGoodNxt; // see RULE_13

    // Power stage controls and status pins, all registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chargeActive   <= 1'b0;
            boostActive    <= 1'b0;
            effectiveLimit <= LIM_100;
            powerGoodNOe_b <= 1'b1;
            statOe_b       <= 1'b1;
            statFaultPull  <= 1'b0;
            faultActive_r  <= 1'b0;
            thermOk_r      <= 1'b1;
            done_r         <= 1'b0;
        end else begin
            chargeActive   <= chargeNxt;
            boostActive    <= boostNxt;
            effectiveLimit <= limitNxt;
            powerGoodNOe_b <= !powerGoodNxt; // see RULE_02
            statOe_b       <= !chargeNxt;    // see RULE_03, RULE_04
            statFaultPull  <= faultNow;      // see RULE_05
            faultActive_r  <= faultDetect;
            thermOk_r      <= thermOk;
            done_r         <= chargeDone;
        end
    end

    // Open-drain data lines only ever pull low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            powerGoodNOut <= 1'b0;
            statOut       <= 1'b0;
            intOut        <= 1'b0;
        end else begin
            powerGoodNOut <= 1'b0;
            statOut       <= 1'b0;
            intOut        <= 1'b0;
        end
    end

    // Events are edges of the state just computed, seen the same cycle
    always_comb begin
        events           = '0;
        events[EV_GOOD]  = powerGoodNxt == powerGoodNOe_b;
        events[EV_CHG]   = chargeNxt != chargeActive;
        events[EV_DONE]  = chargeDone && !done_r;
        events[EV_THERM] = !thermOk && thermOk_r;
        events[EV_FAULT] = faultDetect && !faultActive_r;
        events[EV_BOOST] = boostNxt != boostActive;
    end

    // Wishbone request decode
    assign wbReq   = cyc_i && stb_i && !ack_o;
    assign wbWrite = wbReq && we_i && sel_i[0];

    // Write-one-to-clear; a new event in the same cycle wins
    always_comb begin
        intStatusNxt = intStatus_r | events;
        if (wbWrite && adr_i == INT_STS_OFFS) begin
            intStatusNxt = (intStatus_r & ~dat_i[EV_W-1:0]) | events;
        end
    end

    // Interrupt status, mask and level output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intStatus_r <= '0;
            intMask_r   <= '0;
            irq         <= 1'b0;
        end else begin
            intStatus_r <= intStatusNxt;
            if (wbWrite && adr_i == INT_MSK_OFFS) begin
                intMask_r <= dat_i[EV_W-1:0];
            end
            irq <= |(intStatusNxt & intMask_r);
        end
    end

    // Pin pulse sequencer; events during a pulse are not re-pulsed,
    // since the host reads the sticky status after the first one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulseState_r <= PULSE_IDLE;
            pulseCnt_r   <= '0;
            intOe_b      <= 1'b1;
        end else begin
            unique case (pulseState_r)
                PULSE_IDLE: begin
                    if (|events) begin // see RULE_14
                        pulseState_r <= PULSE_LOW;
                        pulseCnt_r   <= 16'(PULSE_CYCLES - 1);
                        intOe_b      <= 1'b0;
                    end
                end
                PULSE_LOW: begin
                    if (pulseCnt_r == '0) begin // see RULE_06
                        pulseState_r <= PULSE_IDLE;
                        intOe_b      <= 1'b1;
                    end else begin
                        pulseCnt_r <= pulseCnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Control register, byte lane 0 only; upper bits are reserved
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RESET;
        end else if (wbWrite && adr_i == CTRL_OFFS) begin
            ctrl_r                        <= '0;
            ctrl_r[MODE_LSB+1:MODE_LSB]   <= dat_i[MODE_LSB+1:MODE_LSB];
            ctrl_r[LIMIT_LSB+2:LIMIT_LSB] <= dat_i[LIMIT_LSB+2:LIMIT_LSB];
        end
    end

    // Single-wait-state answer; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= wbReq;
            dat_o <= '0;
            if (wbReq && !we_i) begin
                unique case (adr_i)
                    CTRL_OFFS:    dat_o <= ctrl_r;
                    STATUS_OFFS: begin
                        dat_o[STS_GOOD]   <= !powerGoodNOe_b;
                        dat_o[STS_CHG]    <= chargeActive;
                        dat_o[STS_BOOST]  <= boostActive;
                        dat_o[STS_THERM]  <= thermOk_r;
                        dat_o[STS_FAULT]  <= statFaultPull;
                        dat_o[STS_CHGREQ] <= chargeReq;
                        dat_o[STS_LIMLSB+2:STS_LIMLSB] <= effectiveLimit;
                    end
                    INT_STS_OFFS: dat_o[EV_W-1:0] <= intStatus_r;
                    INT_MSK_OFFS: dat_o[EV_W-1:0] <= intMask_r;
                    default:      dat_o <= '0;
                endcase
            end
        end
    end

    // Helper: length of the current interrupt low phase
    logic [15:0] lowLen_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowLen_r <= '0;
        end else if (!intOe_b) begin
            lowLen_r <= lowLen_r + 16'h0001;
        end else begin
            lowLen_r <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_pulse_len;
        $rose(intOe_b) |-> lowLen_r == 16'(PULSE_CYCLES);
    endproperty
    a_pulse_len: assert property (p_pulse_len) // see RULE_06
        else $error("interrupt pulse length wrong");

    property p_fault_int;
        (faultDetect && !faultActive_r && pulseState_r == PULSE_IDLE)
            |=> !intOe_b;
    endproperty
    a_fault_int: assert property (p_fault_int) // see RULE_14
        else $error("fault did not start interrupt pulse");

    property p_stat_charge;
        chargeActive |-> !statOe_b;
    endproperty
    a_stat_charge: assert property (p_stat_charge) // see RULE_03
        else $error("status pin not low while charging");

    property p_stat_release;
        (!chargeReq || chargeDone) |=> statOe_b;
    endproperty
    a_stat_release: assert property (p_stat_release) // see RULE_04
        else $error("status pin not released");

    property p_fault_pull;
        faultDetect |=> statFaultPull;
    endproperty
    a_fault_pull: assert property (p_fault_pull) // see RULE_05
        else $error("fault pull missing");

    property p_boost;
        boostActive |-> $past(modeField) == MODE_BOOST
                        && $past(boostOrLimitSel);
    endproperty
    a_boost: assert property (p_boost) // see RULE_08
        else $error("boost without mode and pin");

    property p_charge_gate;
        chargeActive |-> $past(modeField) == MODE_CHARGE
                         && !$past(chargeEnable_b);
    endproperty
    a_charge_gate: assert property (p_charge_gate) // see RULE_09
        else $error("charging without mode and pin");

    property p_therm;
        !thermOk |=> !chargeActive;
    endproperty
    a_therm: assert property (p_therm) // see RULE_13
        else $error("charging with thermistor out of window");

    property p_limit;
        1'b1 |=> effectiveLimit <= $past(limitCode);
    endproperty
    a_limit: assert property (p_limit) // see RULE_11
        else $error("limit above register setting");

    property p_usb_low;
        (sourceSelect && !boostOrLimitSel) |=> effectiveLimit == LIM_100;
    endproperty
    a_usb_low: assert property (p_usb_low) // see RULE_07
        else $error("USB low limit not applied");

    property p_pg;
        !powerGoodNOe_b |-> $past(supplySense.aboveLockout)
            && $past(supplySense.belowOvp) && $past(supplySense.aboveSleep);
    endproperty
    a_pg: assert property (p_pg) // see RULE_02
        else $error("power good outside supply window");

    c_charge: cover property (chargeActive ##1 chargeDone ##1 statOe_b);
    c_boost: cover property ($rose(boostActive));
    c_pulse: cover property ($rose(intOe_b) && irq);

endmodule

// >>> charger_pkg.sv
// Shared constants and types for the charger pin control logic.
// Assumes a 40 MHz clock and a 32-bit classic Wishbone register port.
package charger_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS    = 8'h00;
    localparam logic [7:0] STATUS_OFFS  = 8'h04;
    localparam logic [7:0] INT_STS_OFFS = 8'h08;
    localparam logic [7:0] INT_MSK_OFFS = 8'h0C;

    // Control register fields and reset value
    localparam int          MODE_LSB   = 4;
    localparam int          LIMIT_LSB  = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0012;

    // Mode configuration field encodings
    localparam logic [1:0] MODE_CHARGE = 2'h1;
    localparam logic [1:0] MODE_BOOST  = 2'h2;

    // Status register fields
    localparam int STS_GOOD   = 0;
    localparam int STS_CHG    = 1;
    localparam int STS_BOOST  = 2;
    localparam int STS_THERM  = 3;
    localparam int STS_FAULT  = 4;
    localparam int STS_CHGREQ = 5;
    localparam int STS_LIMLSB = 8;

    // Event bits of the interrupt status and mask registers
    localparam int EV_GOOD  = 0;
    localparam int EV_CHG   = 1;
    localparam int EV_DONE  = 2;
    localparam int EV_THERM = 3;
    localparam int EV_FAULT = 4;
    localparam int EV_BOOST = 5;
    localparam int EV_W     = 6;

    // Input limit codes, 100 mA up to 3 A
    localparam logic [2:0] LIM_100 = 3'h0;
    localparam logic [2:0] LIM_500 = 3'h2;
    localparam int LIMIT_MA [8] = '{100, 150, 500, 900, 1200, 1500, 2000, 3000};
    localparam int GOOD_MIN_MA  = 30;

    // Interrupt pulse timing
    localparam int CLK_PERIOD_NS    = 25;
    localparam int INT_PULSE_US     = 256;
    localparam int INT_PULSE_CYCLES = INT_PULSE_US * 1000 / CLK_PERIOD_NS;

    // Qualifiers of the input supply from the analog comparators
    typedef struct packed {
        logic aboveLockout;
        logic belowOvp;
        logic aboveSleep;
    } supply_sense_type;

    // Interrupt pulse sequencer
    typedef enum logic {PULSE_IDLE, PULSE_LOW} pulse_state_type;

endpackage

// >>> charger_host_model.sv
// Host-side model: drives the control pins, pulls the open-drain pins up.
// Assumes the charger's pin outputs are registered on clk.
`timescale 1ns/1ps

module charger_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Open-drain pins of the charger
    input  wire logic goodOut,
    input  wire logic goodOe_b,
    input  wire logic statOut,
    input  wire logic statOe_b,
    input  wire logic intOut,
    input  wire logic intOe_b,
    // Control pins, resolved pin levels and interrupt pulse measurements
    output logic      sourceSelect,
    output logic      boostOrLimitSel,
    output logic      chargeEnable_b,
    output logic      goodPin,
    output logic      statPin,
    output logic      intPin,
    output int        pulseCount,
    output int        lastPulseLen
);
    int lowRun;

    // Pins start at defined levels, never floating
    initial begin
        sourceSelect = 1'h0;
        boostOrLimitSel = 1'h0;
        chargeEnable_b = 1'h1;
    end

    // The host changes its pins just after a rising edge
    task automatic drive(input logic s, input logic l, input logic c);
        @(posedge clk);
        sourceSelect <= s;
        boostOrLimitSel <= l;
        chargeEnable_b <= c;
    endtask

    // Pull-ups win whenever a pin is released
    assign goodPin = goodOe_b ? 1'h1 : goodOut;
    assign statPin = statOe_b ? 1'h1 : statOut;
    assign intPin = intOe_b ? 1'h1 : intOut;

    // Measure each low pulse on the interrupt line in clock cycles
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowRun <= 0;
            pulseCount <= 0;
            lastPulseLen <= 0;
        end else if (intPin === 1'h0) begin
            lowRun <= lowRun + 1;
        end else if (lowRun != 0) begin
            pulseCount <= pulseCount + 1;
            lastPulseLen <= lowRun;
            lowRun <= 0;
        end
    end
endmodule

// >>> tb_charger_pin_control.sv
// Self-checking bench for the charger pin control logic.
// Assumes the host model beside it and asserts kept in the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end

module tb_charger_pin_control;
    import charger_pkg::*;
    localparam int PULSE = 8;  // Short pulse keeps the run brief
    logic             clk = 1'h0;
    logic             rst_b = 1'h0;
    logic             cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0]       sel = 4'hF;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wdat = 32'h0000_0000, rdat, q;
    logic             ack, src, lim, ceB, goodPin, statPin, intPin;
    supply_sense_type supply = 3'h7;
    logic [2:0]       resPin = 3'h7, effLimit;
    logic             thermA = 1'h1, thermB = 1'h1;
    logic             chgDone = 1'h0, fault = 1'h0;
    logic             chgAct, boostAct, goodOut, goodOe_b, statOut, statOe_b;
    logic             statPull, intOut, intOe_b, irq;
    int               pulses, pulseLen, base, e;
    int               mismatches = 0, compares = 0, cycles = 0;

    charger_pin_control #(.PULSE_CYCLES(PULSE)) u_charger_pin_control (
        .clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .sourceSelect(src), .boostOrLimitSel(lim), .chargeEnable_b(ceB),
        .supplySense(supply), .inputLimitResistorPin(resPin),
        .thermistorSenseA(thermA), .thermistorSenseB(thermB),
        .chargeDone(chgDone), .faultDetect(fault), .chargeActive(chgAct),
        .boostActive(boostAct), .effectiveLimit(effLimit),
        .powerGoodNOut(goodOut), .powerGoodNOe_b(goodOe_b),
        .statOut(statOut), .statOe_b(statOe_b), .statFaultPull(statPull),
        .intOut(intOut), .intOe_b(intOe_b), .irq(irq));

    charger_host_model u_charger_host_model (
        .clk(clk), .rst_b(rst_b), .goodOut(goodOut), .goodOe_b(goodOe_b),
        .statOut(statOut), .statOe_b(statOe_b), .intOut(intOut),
        .intOe_b(intOe_b), .sourceSelect(src), .boostOrLimitSel(lim),
        .chargeEnable_b(ceB), .goodPin(goodPin), .statPin(statPin),
        .intPin(intPin), .pulseCount(pulses), .lastPulseLen(pulseLen));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // Cycle ceiling far above the several hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; the slave's latency is not assumed
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'h1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
                         input string nm);
        wb(1'h0, a, 32'h0000_0000);
        `CHK(nm, x, q)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_regs();
        rdchk(CTRL_OFFS, CTRL_RESET, "ctrl reset");
        wr(8'h10, 32'hFFFF_FFFF);
        rdchk(8'h10, 32'h0000_0000, "unmapped");
        sel <= 4'hE;  // Byte 0 disabled: write must not land
        wr(CTRL_OFFS, 32'h0000_0000);
        sel <= 4'hF;
        rdchk(CTRL_OFFS, CTRL_RESET, "sel byte0 off");
        wr(INT_MSK_OFFS, 32'h0000_002A);
        rdchk(INT_MSK_OFFS, 32'h0000_002A, "mask");
        $display("test regs done");
    endtask

    // Every mode code against every pin pair
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                wr(CTRL_OFFS, 32'(m * 16 + 7));
                u_charger_host_model.drive(1'h0, p[0], p[1]);
                settle(4);
                `CHK("charge", (m == 1 && !p[1]), chgAct)
                `CHK("boost", (m == 2 && p[0]), boostAct)
            end
        end
        $display("test modes done");
    endtask

    task automatic t_limit();
        u_charger_host_model.drive(1'h0, 1'h0, 1'h0);
        for (int r = 0; r < 8; r++) begin
            for (int g = 0; g < 8; g++) begin
                resPin <= 3'(r);
                wr(CTRL_OFFS, 32'(16 + g));
                settle(3);
                e = (r < 2) ? 2 : r;
                e = (g < e) ? g : e;
                `CHK("limit", 3'(e), effLimit)
            end
        end
        // USB host source: pin low forces 100 mA, high caps at 500 mA
        resPin <= 3'h7;
        for (int k = 0; k < 4; k++) begin
            wr(CTRL_OFFS, k[1] ? 32'h0000_0011 : 32'h0000_0017);
            u_charger_host_model.drive(1'h1, k[0], 1'h0);
            settle(4);
            e = !k[0] ? LIM_100 : (k[1] ? 1 : LIM_500);
            `CHK("usb limit", 3'(e), effLimit)
        end
        u_charger_host_model.drive(1'h0, 1'h0, 1'h0);
        $display("test limit done");
    endtask

    task automatic t_pgood();
        for (int b = 0; b < 4; b++) begin
            supply <= (b == 3) ? 3'h7 : ~(3'h1 << b);
            settle(3);
            `CHK("power good", (b != 3), goodPin)
        end
        $display("test pgood done");
    endtask

    task automatic t_stat();
        wr(CTRL_OFFS, 32'h0000_0017);
        settle(3);
        `CHK("stat charging", 1'h0, statPin)
        rdchk(STATUS_OFFS, 32'h0000_072B, "status");
        wr(STATUS_OFFS, 32'h0000_0000);
        rdchk(STATUS_OFFS, 32'h0000_072B, "status ro");
        chgDone <= 1'h1;
        settle(3);
        `CHK("stat done", 1'h1, statPin)
        chgDone <= 1'h0;
        u_charger_host_model.drive(1'h0, 1'h0, 1'h1);
        settle(3);
        `CHK("stat off", 1'h1, statPin)
        u_charger_host_model.drive(1'h0, 1'h0, 1'h0);
        fault <= 1'h1;
        settle(3);
        `CHK("fault pull", 1'h1, statPull)
        fault <= 1'h0;
        settle(3);
        `CHK("fault gone", 1'h0, statPull)
        // Each thermistor alone suspends charging while out of window
        for (int k = 0; k < 2; k++) begin
            {thermA, thermB} <= k ? 2'h1 : 2'h2;
            settle(3);
            `CHK("therm stop", 1'h0, chgAct)
            settle(6);
            `CHK("therm hold", 1'h0, chgAct)
            {thermA, thermB} <= 2'h3;
            settle(3);
            `CHK("therm back", 1'h1, chgAct)
        end
        $display("test stat done");
    endtask

    task automatic t_int();
        settle(3 * PULSE);
        // Every event kind has happened once by now, none cleared yet
        rdchk(INT_STS_OFFS, 32'h0000_003F, "int all events");
        wr(INT_MSK_OFFS, 32'(1 << EV_FAULT));
        wr(INT_STS_OFFS, 32'h0000_003F);
        rdchk(INT_STS_OFFS, 32'h0000_0000, "int cleared");
        base = pulses;
        @(posedge clk);
        fault <= 1'h1;
        @(posedge clk);
        #1;
        `CHK("int at once", 1'h0, intPin)
        // Fault drops mid-pulse: no second pulse, no stretch
        repeat (3) @(posedge clk);
        fault <= 1'h0;
        settle(PULSE + 6);
        `CHK("one pulse", base + 1, pulses)
        `CHK("pulse len", PULSE, pulseLen)
        `CHK("irq on", 1'h1, irq)
        rdchk(INT_STS_OFFS, 32'h0000_0012, "int status");
        wr(INT_MSK_OFFS, 32'h0000_0000);
        settle(2);
        `CHK("irq masked", 1'h0, irq)
        wr(INT_MSK_OFFS, 32'(1 << EV_FAULT));
        settle(2);
        `CHK("irq unmasked", 1'h1, irq)
        wr(INT_STS_OFFS, 32'(1 << EV_FAULT));
        settle(2);
        `CHK("irq cleared", 1'h0, irq)
        $display("test int done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        settle(2);
        t_regs();
        t_modes();
        t_limit();
        t_pgood();
        t_stat();
        t_int();
        complete_run();
    end
endmodule
